// ---- olx_defines.vh ----
// Purpose: constants for the or/pointer-load execution block
// Assumes: 16-bit instruction words, four-phase instruction cycle
// Notes: opcode fields are matched on the upper word bits
`ifndef OLX_DEFINES_VH
`define OLX_DEFINES_VH
// ***********************************
// opcode patterns
// ***********************************
`define OLX_OP_ORLIT      8'h09
`define OLX_OP_ORFILE     6'h04
`define OLX_OP_LDPTR      8'hEE
`define OLX_LDPTR_ZERO    2'h0
`define OLX_OP_SECOND     4'hF
// ***********************************
// field positions, index limit and pointer count
// ***********************************
`define OLX_BIT_DEST      9
`define OLX_BIT_ACCESS    8
`define OLX_INDEX_LIMIT   8'h5F
`define OLX_PTR_COUNT     3
// ***********************************
// phases and reset values
// ***********************************
`define OLX_Q1            2'h0
`define OLX_Q2            2'h1
`define OLX_Q3            2'h2
`define OLX_Q4            2'h3
`define OLX_WREG_RESET    8'h00
`define OLX_PTR_RESET     12'h000
`endif

// ---- olx_exec_chk_assertions.sv ----
// Purpose: port-level checks of the or/pointer-load block
// Assumes: phase_r shows the phase of the edge just taken
// Notes: attached to the top by bind
module olx_exec_chk #(
   parameter PTR_W = 12
) (
   input logic             ref_clk,
   input logic             rst,
   input logic [11:0]      memAddr_r,
   input logic             memWrEn_r,
   input logic [7:0]       workingReg_r,
   input logic             flagNeg_r,
   input logic             flagZero_r,
   input logic [PTR_W-1:0] pointer0_r,
   input logic [PTR_W-1:0] pointer1_r,
   input logic [PTR_W-1:0] pointer2_r,
   input logic [1:0]       phase_r,
   input logic             busy_r
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // checks
   // ****
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_load2;
      busy_r [*4] ##1 !busy_r;
   endsequence
   property p_wreg_q4;
      !$stable(workingReg_r) |-> phase_r == 2'h3;
   endproperty
   a_wreg_q4: assert property (p_wreg_q4) else $error("working reg moved off Q4");
   property p_or_sets;
      !$stable(workingReg_r) |-> (workingReg_r & $past(workingReg_r)) == $past(workingReg_r);
   endproperty
   a_or_sets: assert property (p_or_sets) else $error("working reg bit cleared");
   property p_wr_pulse;
      memWrEn_r |-> phase_r == 2'h3 ##1 !memWrEn_r;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("bad write pulse");
   property p_addr_q1;
      !$stable(memAddr_r) |-> phase_r == 2'h0;
   endproperty
   a_addr_q1: assert property (p_addr_q1) else $error("address moved off Q1");
   property p_ptr_q4;
      !$stable({pointer0_r, pointer1_r, pointer2_r}) |-> phase_r == 2'h3;
   endproperty
   a_ptr_q4: assert property (p_ptr_q4) else $error("pointer moved off Q4");
   property p_load2;
      $rose(busy_r) |-> phase_r == 2'h3 ##0 s_load2;
   endproperty
   a_load2: assert property (p_load2) else $error("load not two cycles");
   property p_flags;
      !$stable(workingReg_r) |-> flagZero_r == (workingReg_r == 8'h00) && flagNeg_r == workingReg_r[7];
   endproperty
   a_flags: assert property (p_flags) else $error("flags disagree with result");
   property p_load_flags;
      busy_r |-> $stable({flagNeg_r, flagZero_r}) ##1 $stable({flagNeg_r, flagZero_r});
   endproperty
   a_load_flags: assert property (p_load_flags) else $error("flags moved in load");
endmodule
bind olx_or_and_pointer_load_exec olx_exec_chk #(.PTR_W(PTR_W)) chk_i (.*);

// ---- olx_or_and_pointer_load_exec.v ----
// Purpose: execution of or-literal, or-with-file and pointer-load opcodes
// Assumes: instruction word held stable from Q1 to Q4 of its cycle
// Notes: data memory read is combinational, write strobe issued at Q4
// Overview of operation
// - or-literal ORs 8-bit immediate into working register, result stays there
// - or-with-file ORs working register with location; dest bit picks target
// - access bit 0 uses access bank, 1 uses bank select register
// - access 0, extended set on, address up to 95: indexed literal offset
// - pointer load puts 12-bit immediate into pointer 0..2, two words
// - first cycle writes high byte, second cycle writes low byte
`include "olx_defines.vh"
module olx_or_and_pointer_load_exec #(
   parameter PTR_W = 12
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [15:0] instrWord,
   input  wire        instrValid,
   input  wire        extendedEn,
   input  wire [3:0]  bankSelectRegister,
   input  wire [7:0]  memRdData,
   output reg  [11:0] memAddr_r,
   output reg  [7:0]  memWrData_r,
   output reg         memWrEn_r,
   output reg  [7:0]  workingReg_r,
   output reg         flagNeg_r,
   output reg         flagZero_r,
   output reg  [PTR_W-1:0] pointer0_r,
   output reg  [PTR_W-1:0] pointer1_r,
   output reg  [PTR_W-1:0] pointer2_r,
   output reg  [1:0]  phase_r,
   output reg         busy_r
);
   // ***********************************
   // phase sequencer
   // ***********************************
   wire [1:0] phase;
   olx_phase_gen olx_phase_gen_i (
      .ref_clk (ref_clk),
      .rst     (rst),
      .phase_r (phase)
   );

   // ***********************************
   // decode
   // ***********************************
   localparam ST_IDLE = 1'b0;
   localparam ST_LOW  = 1'b1;
   reg        state_r;
   reg        state_nxt;
   reg [1:0]  ptrSel_r;

   wire isOrLit  = instrValid && (instrWord[15:8] == `OLX_OP_ORLIT);
   wire isOrFile = instrValid && (instrWord[15:10] == `OLX_OP_ORFILE);
   wire isLdPtr  = instrValid && (instrWord[15:8] == `OLX_OP_LDPTR)
                   && (instrWord[7:6] == `OLX_LDPTR_ZERO) && (instrWord[5:4] != 2'h3);
   wire isSecond = instrValid && (instrWord[15:12] == `OLX_OP_SECOND);
   wire destFile = instrWord[`OLX_BIT_DEST];
   wire accessA  = instrWord[`OLX_BIT_ACCESS];

   // access bank: low half maps to bank 0, high half to bank 15
   function [11:0] resolveAddr;
      input [7:0] f;
      input       a;
      input [3:0] bank_select_register;
      input       ext;
      input [11:0] idx;
      begin
         if (a) begin
            resolveAddr = {bank_select_register, f};
         end else if (ext && (f <= `OLX_INDEX_LIMIT)) begin
            resolveAddr = idx + {4'h0, f};
         end else begin
            resolveAddr = {{4{f[7]}}, f};
         end
      end
   endfunction

   // indexed literal offset is relative to pointer 2
   wire [11:0] fileAddr = resolveAddr(instrWord[7:0], accessA, bankSelectRegister,
                                      extendedEn, pointer2_r[11:0]);
   wire [7:0]  orLitRes  = workingReg_r | instrWord[7:0];
   wire [7:0]  orFileRes = workingReg_r | memRdData;

   // ***********************************
   // pointer write enables
   // ***********************************
   // selector 3 never reaches here, decode refuses it
   function [2:0] ptrHit;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    ptrHit = 3'h1;
            2'h1:    ptrHit = 3'h2;
            default: ptrHit = 3'h4;
         endcase
      end
   endfunction

   wire               isQ4   = (phase == `OLX_Q4);
   wire               hiWrEn = isQ4 && (state_r == ST_IDLE) && isLdPtr;
   wire               loWrEn = isQ4 && (state_r == ST_LOW) && isSecond;
   wire [2:0]         hiSel  = ptrHit(instrWord[5:4]);
   wire [2:0]         loSel  = ptrHit(ptrSel_r);

   wire [3*PTR_W-1:0] ptrCur = {pointer2_r, pointer1_r, pointer0_r};
   wire [3*PTR_W-1:0] ptrNxt;

   // high byte in first word, low byte in second; a pointer keeps the other half
   genvar gi;
   generate
      for (gi = 0; gi < `OLX_PTR_COUNT; gi = gi + 1) begin : g_ptr
         wire [PTR_W-1:0] cur = ptrCur[gi*PTR_W +: PTR_W];
         assign ptrNxt[gi*PTR_W +: PTR_W] =
            (hiWrEn && hiSel[gi]) ? {instrWord[3:0], cur[7:0]} :
            (loWrEn && loSel[gi]) ? {cur[PTR_W-1:8], instrWord[7:0]} :
            cur;
      end
   endgenerate

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (phase == `OLX_Q4 && isLdPtr) begin
               state_nxt = ST_LOW;
            end
         end
         ST_LOW: begin
            if (phase == `OLX_Q4) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // ***********************************
   // sequencing state
   // ***********************************
   always @(posedge ref_clk) begin
      if (rst) begin
         state_r  <= ST_IDLE;
         ptrSel_r <= 2'h0;
         phase_r  <= `OLX_Q1;
         busy_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         phase_r <= phase;
         // busy follows next state, so it rises with the high-byte write
         busy_r  <= (state_nxt == ST_LOW);
         // selector kept for the second word, the first is gone by then
         if (hiWrEn) begin
            ptrSel_r <= instrWord[5:4];
         end
      end
   end

   // ***********************************
   // data memory port
   // ***********************************
   always @(posedge ref_clk) begin
      if (rst) begin
         memAddr_r   <= 12'h000;
         memWrData_r <= 8'h00;
         memWrEn_r   <= 1'b0;
      end else begin
         memWrEn_r <= 1'b0;
         // address presented from Q2 so read data is valid by Q4
         if (isOrFile && phase == `OLX_Q1) begin
            memAddr_r <= fileAddr;
         end
         // write data latched at Q4, strobe stands for the following cycle
         if (isQ4 && state_r == ST_IDLE && isOrFile && destFile) begin
            memWrData_r <= orFileRes;
            memWrEn_r   <= 1'b1;
         end
      end
   end

   // ***********************************
   // working register and status flags
   // ***********************************
   // pointer load falls through here, so flags hold across both of its words
   always @(posedge ref_clk) begin
      if (rst) begin
         workingReg_r <= `OLX_WREG_RESET;
         flagNeg_r    <= 1'b0;
         flagZero_r   <= 1'b0;
      end else if (isQ4 && state_r == ST_IDLE) begin
         if (isOrLit) begin
            workingReg_r <= orLitRes;
            flagNeg_r    <= orLitRes[7];
            flagZero_r   <= (orLitRes == 8'h00);
         end else if (isOrFile) begin
            flagNeg_r  <= orFileRes[7];
            flagZero_r <= (orFileRes == 8'h00);
            if (!destFile) begin
               workingReg_r <= orFileRes;
            end
         end
      end
   end

   // ***********************************
   // pointer registers
   // ***********************************
   // a malformed second word aborts, high byte stays loaded
   // each pointer reloads its own next value every edge
   always @(posedge ref_clk) begin
      if (rst) begin
         pointer0_r <= `OLX_PTR_RESET;
         pointer1_r <= `OLX_PTR_RESET;
         pointer2_r <= `OLX_PTR_RESET;
      end else begin
         pointer0_r <= ptrNxt[PTR_W-1:0];
         pointer1_r <= ptrNxt[2*PTR_W-1:PTR_W];
         pointer2_r <= ptrNxt[3*PTR_W-1:2*PTR_W];
      end
   end
endmodule

// ---- olx_or_and_pointer_load_exec_tb.sv ----
// Purpose: directed bench of the or/pointer-load block
// Assumes: one instruction per four edges
// Notes: idle cycle after each op lets outputs settle
module olx_or_and_pointer_load_exec_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] instrWord = 16'h0000;
   logic        instrValid = 1'b0;
   logic        extendedEn = 1'b0;
   logic [3:0]  bankSelectRegister = 4'h0;
   wire  [7:0]  memRdData, memWrData_r, workingReg_r;
   wire  [11:0] memAddr_r, pointer0_r, pointer1_r, pointer2_r;
   wire  [1:0]  phase_r;
   wire         memWrEn_r, flagNeg_r, flagZero_r, busy_r;
   int          err_count = 0;
   int          n_compared = 0;
   int          wn = 0;
   logic [7:0]  w = 8'h00;
   logic [11:0] wa;
   logic [7:0]  wd;
   olx_or_and_pointer_load_exec olx_or_and_pointer_load_exec_i (
      .ref_clk            (ref_clk),
      .rst                (rst),
      .instrWord          (instrWord),
      .instrValid         (instrValid),
      .extendedEn         (extendedEn),
      .bankSelectRegister (bankSelectRegister),
      .memRdData          (memRdData),
      .memAddr_r          (memAddr_r),
      .memWrData_r        (memWrData_r),
      .memWrEn_r          (memWrEn_r),
      .workingReg_r       (workingReg_r),
      .flagNeg_r          (flagNeg_r),
      .flagZero_r         (flagZero_r),
      .pointer0_r         (pointer0_r),
      .pointer1_r         (pointer1_r),
      .pointer2_r         (pointer2_r),
      .phase_r            (phase_r),
      .busy_r             (busy_r)
   );
   always #5 ref_clk = ~ref_clk;
   // address-dependent data, so a wrong address shows
   function automatic logic [7:0] rd(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], 4'h1};
   endfunction
   assign memRdData = rd(memAddr_r);
   always @(posedge ref_clk) begin
      if (memWrEn_r) begin
         wa <= memAddr_r;
         wd <= memWrData_r;
         wn <= wn + 1;
      end
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task ex(input logic [15:0] word);
      instrWord <= word;
      instrValid <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
   task idle;
      instrValid <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task orlit(input logic [7:0] k);
      ex({8'h09, k});
      idle;
      w = w | k;
      chk(workingReg_r, w);
      chk({flagNeg_r, flagZero_r}, {w[7], w == 8'h00});
   endtask
   task orfile(input logic [7:0] f, input logic d, input logic a, input logic [11:0] adr);
      logic [7:0] r;
      int         n0;
      r = w | rd(adr);
      n0 = wn;
      ex({6'h04, d, a, f});
      idle;
      chk(memAddr_r, adr);
      chk(16'(wn - n0), {15'h0000, d});
      if (d) begin
         chk(wd, r);
         chk(wa, adr);
      end else begin
         w = r;
      end
      chk(workingReg_r, w);
      chk({flagNeg_r, flagZero_r}, {r[7], r == 8'h00});
   endtask
   task ldptr(input logic [1:0] s, input logic [11:0] k);
      logic [1:0] fl;
      fl = {flagNeg_r, flagZero_r};
      ex({8'hEE, 2'b00, s, k[11:8]});
      instrWord <= {8'hF0, k[7:0]};
      @(posedge ref_clk);
      chk({15'h0000, busy_r}, 16'h0001);
      repeat (3) @(posedge ref_clk);
      idle;
      chk({15'h0000, busy_r}, 16'h0000);
      chk(s == 0 ? pointer0_r : s == 1 ? pointer1_r : pointer2_r, k);
      chk({flagNeg_r, flagZero_r}, fl);
   endtask
   task t_refuse;
      ex(16'hEE15);
      ex(16'h0000);
      idle;
      chk(pointer1_r, 12'h523);
      ex(16'hEE35);
      ex(16'hF0FF);
      idle;
      chk({pointer0_r, pointer1_r, pointer2_r}, {12'hABC, 12'h523, 12'h3AB});
   endtask
   task stop_test;
      if (err_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      orlit(8'h00);
      orlit(8'h9A);
      orlit(8'h35);
      ldptr(2'h0, 12'hABC);
      ldptr(2'h1, 12'h123);
      ldptr(2'h2, 12'h3AB);
      t_refuse;
      orfile(8'h20, 1'b0, 1'b0, 12'h020);
      orfile(8'h85, 1'b1, 1'b0, 12'hF85);
      bankSelectRegister <= 4'h3;
      orfile(8'h12, 1'b1, 1'b1, 12'h312);
      extendedEn <= 1'b1;
      orfile(8'h5F, 1'b0, 1'b0, 12'h40A);
      orfile(8'h60, 1'b1, 1'b0, 12'h060);
      stop_test;
   end
endmodule

// ---- olx_phase_gen.v ----
// Purpose: four-phase instruction cycle sequencer
// Assumes: synchronous active-high reset
// Notes: one ref_clk edge per phase
`include "olx_defines.vh"
module olx_phase_gen (
   input  wire       ref_clk,
   input  wire       rst,
   output reg  [1:0] phase_r
);
   always @(posedge ref_clk) begin
      if (rst) begin
         phase_r <= `OLX_Q1;
      end else begin
         phase_r <= phase_r + 2'h1;
      end
   end
endmodule
